// ==== shared/srdr_consts.svh ====
// constants of the sensor result data register bank
`ifndef SRDR_CONSTS_SVH
`define SRDR_CONSTS_SVH

// register offsets on the host read port
`define SRDR_ADDR_STATUS   8'h00
`define SRDR_ADDR_P_HIGH   8'h01
`define SRDR_ADDR_P_MID    8'h02
`define SRDR_ADDR_P_LOW    8'h03
`define SRDR_ADDR_T_HIGH   8'h04
`define SRDR_ADDR_T_LOW    8'h05
`define SRDR_ADDR_PD_HIGH  8'h07
`define SRDR_ADDR_PD_MID   8'h08
`define SRDR_ADDR_PD_LOW   8'h09
`define SRDR_ADDR_TD_HIGH  8'h0a
`define SRDR_ADDR_TD_LOW   8'h0b

// reset values
`define SRDR_BYTE_RESET    8'h00
`define SRDR_PRES_RESET    20'h00000
`define SRDR_TEMP_RESET    12'h000
`define SRDR_NIBBLE_ZERO   4'h0

// fifo mode field value for fifo disabled
`define SRDR_FMODE_OFF     2'h0

// status byte bit positions
`define SRDR_ST_COMBINED_OVERWRITE_FLAG       7
`define SRDR_ST_POW        6
`define SRDR_ST_TOW        5
`define SRDR_ST_COMBINED_READY_FLAG       3
`define SRDR_ST_PDR        2
`define SRDR_ST_TDR        1

`endif

// ==== shared/srdr_pkg.sv ====
// types of the sensor result data register bank
package srdr_pkg;
   typedef logic [7:0]  srdr_byte_t;
   typedef logic [19:0] srdr_pres_t;
   typedef logic [11:0] srdr_temp_t;
   typedef logic [1:0]  srdr_fmode_t;
endpackage

// ==== verilog/srdr_delta.sv ====
// difference of each sample against the one before it
`timescale 1ns/1ps
module srdr_delta #(
   parameter int W = 20
) (
   // clock and reset
   input  wire logic         mclk_in,
   input  wire logic         sys_rst_in,
   // sample in
   input  wire logic         load_in,
   input  wire logic [W-1:0] value_in,
   // difference out
   output logic      [W-1:0] delta_out
);
   logic [W-1:0] prev;

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         prev      <= '0;
         delta_out <= '0;
      end else if (load_in) begin
         prev      <= value_in;
         delta_out <= value_in - prev;
      end
   end

   delta_value_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      load_in |=> delta_out == W'($past(value_in) - $past(prev)))
      else $error("delta register does not hold the sample difference");
endmodule

// ==== verilog/srdr_flag.sv ====
// sticky data-ready and overwrite pair
`timescale 1ns/1ps
module srdr_flag (
   // clock and reset
   input  wire logic mclk_in,
   input  wire logic sys_rst_in,
   // events
   input  wire logic set_in,
   input  wire logic clear_in,
   // flags
   output logic      ready_out,
   output logic      over_out
);
   // set wins over a clear in the same cycle
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         ready_out <= 1'b0;
      end else begin
         ready_out <= set_in | (ready_out & ~clear_in);
      end
   end

   // a new sample while the old one is unread is an overwrite
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         over_out <= 1'b0;
      end else begin
         over_out <= (set_in & ready_out) | (over_out & ~clear_in);
      end
   end

   set_wins_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      set_in |=> ready_out)
      else $error("ready flag lost an event");

   over_cause_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      $rose(over_out) |-> $past(set_in) && $past(ready_out))
      else $error("overwrite flag set without unread data");
endmodule

// ==== verilog/srdr_top.sv ====
// sensor result data register bank with its read port
//
// Operation
// - height bit picks altitude or pressure results
// - altitude result is signed Q16.4
// - pressure result is unsigned Q18.2
// - status and results auto-increment from zero
// - temperature result is signed Q8.4
// - fifo off: results track latest sample
// - pressure delta is change from previous
// - altitude delta is signed, fraction bits 7:4
// - pressure delta unsigned, fraction bits 5:4
// - temperature delta is signed 12-bit change
// - deltas update in every fifo mode
// - pressure flags need pressure event enable
// - temperature flags need temperature event enable
// - combined flags need data-ready event mode
// - fifo off: pressure high read clears pressure overwrite
// - fifo off: temperature high read clears temperature ready
`timescale 1ns/1ps
`include "srdr_consts.svh"
module srdr_top (
   // clock and reset
   input  wire logic                 mclk_in,
   input  wire logic                 sys_rst_in,
   // configuration from the control registers
   input  wire logic                 height_mode_select_in,
   input  wire srdr_pkg::srdr_fmode_t fifo_mode_in,
   input  wire logic                 pressure_event_enable_in,
   input  wire logic                 temperature_event_enable_in,
   input  wire logic                 data_ready_event_mode_in,
   // samples from the measurement engine
   input  wire logic                 pres_valid_in,
   input  wire srdr_pkg::srdr_pres_t pres_data_in,
   input  wire srdr_pkg::srdr_pres_t alt_data_in,
   input  wire logic                 temp_valid_in,
   input  wire srdr_pkg::srdr_temp_t temp_data_in,
   // fifo data port read, from the fifo block
   input  wire logic                 fifo_data_read_in,
   // host byte read port, from the serial front end
   input  wire logic                 addr_load_in,
   input  wire srdr_pkg::srdr_byte_t addr_in,
   input  wire logic                 rd_strobe_in,
   output srdr_pkg::srdr_byte_t      rd_data_out,
   output logic                      rd_valid_out,
   // status flags
   output srdr_pkg::srdr_byte_t      status_out
);
   import srdr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   srdr_pres_t  pres_result;
   srdr_temp_t  temp_result;
   srdr_pres_t  pres_delta;
   srdr_temp_t  temp_delta;
   srdr_pres_t  sel_sample;
   srdr_byte_t  rd_ptr;
   srdr_byte_t  next_rd_ptr;
   logic        fifo_off;
   logic        read_p_high;
   logic        read_t_high;
   logic        pres_set;
   logic        temp_set;
   logic        comb_set;
   logic        pres_clear;
   logic        temp_clear;
   logic        comb_clear;
   logic        pres_ready;
   logic        pres_over;
   logic        temp_ready;
   logic        temp_over;
   logic        comb_ready;
   logic        comb_over;

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // low byte: four data bits above a zero nibble
   function automatic srdr_byte_t low_byte(input logic [3:0] frac);
      return {frac, `SRDR_NIBBLE_ZERO};
   endfunction

   function automatic srdr_byte_t byte_at(input srdr_byte_t addr,
                                          input srdr_byte_t status,
                                          input srdr_pres_t pres,
                                          input srdr_temp_t temp,
                                          input srdr_pres_t pdel,
                                          input srdr_temp_t tdel);
      srdr_byte_t val;
      val = `SRDR_BYTE_RESET;
      case (addr)
         `SRDR_ADDR_STATUS:  val = status;
         `SRDR_ADDR_P_HIGH:  val = pres[19:12];
         `SRDR_ADDR_P_MID:   val = pres[11:4];
         `SRDR_ADDR_P_LOW:   val = low_byte(pres[3:0]);
         `SRDR_ADDR_T_HIGH:  val = temp[11:4];
         `SRDR_ADDR_T_LOW:   val = low_byte(temp[3:0]);
         `SRDR_ADDR_PD_HIGH: val = pdel[19:12];
         `SRDR_ADDR_PD_MID:  val = pdel[11:4];
         `SRDR_ADDR_PD_LOW:  val = low_byte(pdel[3:0]);
         `SRDR_ADDR_TD_HIGH: val = tdel[11:4];
         `SRDR_ADDR_TD_LOW:  val = low_byte(tdel[3:0]);
         default:            val = `SRDR_BYTE_RESET;
      endcase
      return val;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // sample selection and result registers

   assign fifo_off = (fifo_mode_in == `SRDR_FMODE_OFF);

   assign sel_sample = height_mode_select_in ? alt_data_in : pres_data_in;

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         pres_result <= `SRDR_PRES_RESET;
      end else if (pres_valid_in && fifo_off) begin
         pres_result <= sel_sample;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         temp_result <= `SRDR_TEMP_RESET;
      end else if (temp_valid_in && fifo_off) begin
         temp_result <= temp_data_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // delta registers, loaded on every sample

   srdr_delta #(
      .W          (20)
   ) u_pres_delta (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .load_in    (pres_valid_in),
      .value_in   (sel_sample),
      .delta_out  (pres_delta)
   );

   srdr_delta #(
      .W          (12)
   ) u_temp_delta (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .load_in    (temp_valid_in),
      .value_in   (temp_data_in),
      .delta_out  (temp_delta)
   );

   ////////////////////////////////////////////////////////////////////////////
   // host read port

   assign next_rd_ptr = addr_load_in ? addr_in
                      : (rd_strobe_in ? rd_ptr + 8'h01 : rd_ptr);

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         rd_ptr <= `SRDR_ADDR_STATUS;
      end else begin
         rd_ptr <= next_rd_ptr;
      end
   end

   // read data with zero reserved nibbles
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         rd_data_out <= `SRDR_BYTE_RESET;
      end else if (rd_strobe_in && !addr_load_in) begin
         rd_data_out <= byte_at(rd_ptr, status_out, pres_result, temp_result,
                                pres_delta, temp_delta);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         rd_valid_out <= 1'b0;
      end else begin
         rd_valid_out <= rd_strobe_in && !addr_load_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event flags

   assign read_p_high = rd_strobe_in && !addr_load_in && (rd_ptr == `SRDR_ADDR_P_HIGH);
   assign read_t_high = rd_strobe_in && !addr_load_in && (rd_ptr == `SRDR_ADDR_T_HIGH);

   assign pres_set = pres_valid_in && pressure_event_enable_in;
   assign temp_set = temp_valid_in && temperature_event_enable_in;
   assign comb_set = (pres_valid_in || temp_valid_in) && data_ready_event_mode_in;

   assign pres_clear = fifo_off ? read_p_high : fifo_data_read_in;
   assign temp_clear = fifo_off ? read_t_high : fifo_data_read_in;
   assign comb_clear = fifo_off ? (read_p_high || read_t_high) : fifo_data_read_in;

   srdr_flag u_pres_flag (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .set_in     (pres_set),
      .clear_in   (pres_clear),
      .ready_out  (pres_ready),
      .over_out   (pres_over)
   );

   srdr_flag u_temp_flag (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .set_in     (temp_set),
      .clear_in   (temp_clear),
      .ready_out  (temp_ready),
      .over_out   (temp_over)
   );

   srdr_flag u_comb_flag (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .set_in     (comb_set),
      .clear_in   (comb_clear),
      .ready_out  (comb_ready),
      .over_out   (comb_over)
   );

   // status byte, reserved bits zero
   always_comb begin
      status_out                 = `SRDR_BYTE_RESET;
      status_out[`SRDR_ST_COMBINED_OVERWRITE_FLAG]  = comb_over;
      status_out[`SRDR_ST_POW]   = pres_over;
      status_out[`SRDR_ST_TOW]   = temp_over;
      status_out[`SRDR_ST_COMBINED_READY_FLAG]  = comb_ready;
      status_out[`SRDR_ST_PDR]   = pres_ready;
      status_out[`SRDR_ST_TDR]   = temp_ready;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   alt_load_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      pres_valid_in && fifo_off && height_mode_select_in
      |=> pres_result == $past(alt_data_in))
      else $error("altitude mode did not load altitude");

   baro_load_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      pres_valid_in && fifo_off && !height_mode_select_in
      |=> pres_result == $past(pres_data_in))
      else $error("pressure mode did not load pressure");

   high_byte_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      read_p_high |=> rd_data_out == $past(pres_result[19:12]) && rd_valid_out)
      else $error("result high byte wrong");

   ptr_step_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      rd_strobe_in && !addr_load_in |=> rd_ptr == $past(rd_ptr) + 8'h01)
      else $error("read pointer did not advance");

   temp_byte_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      read_t_high |=> rd_data_out == $past(temp_result[11:4]))
      else $error("temperature high byte wrong");

   fifo_hold_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      !fifo_off |=> $stable(pres_result) && $stable(temp_result))
      else $error("result changed while fifo enabled");

   delta_any_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      pres_valid_in && !fifo_off
      |=> pres_delta == 20'($past(sel_sample) - $past(u_pres_delta.prev)))
      else $error("pressure delta not loaded in fifo mode");

   tdelta_byte_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      rd_strobe_in && !addr_load_in && rd_ptr == `SRDR_ADDR_TD_LOW
      |=> rd_data_out == {$past(temp_delta[3:0]), `SRDR_NIBBLE_ZERO})
      else $error("temperature delta low byte wrong");

   low_nibble_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      rd_strobe_in && !addr_load_in
      && (rd_ptr == `SRDR_ADDR_P_LOW || rd_ptr == `SRDR_ADDR_PD_LOW)
      |=> rd_data_out[3:0] == `SRDR_NIBBLE_ZERO)
      else $error("reserved nibble not zero");

   pres_gate_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      $rose(pres_ready) |-> $past(pres_valid_in && pressure_event_enable_in))
      else $error("pressure ready set without enable");

   temp_gate_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      $rose(temp_ready) |-> $past(temp_valid_in && temperature_event_enable_in))
      else $error("temperature ready set without enable");

   comb_gate_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      $rose(comb_ready) |-> $past(data_ready_event_mode_in))
      else $error("combined ready set without event mode");

   pover_clear_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      read_p_high && fifo_off && !pres_set |=> !pres_over)
      else $error("pressure overwrite not cleared by read");

   tready_clear_a: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      read_t_high && fifo_off && !temp_set |=> !temp_ready)
      else $error("temperature ready not cleared by read");
endmodule

// ==== dv/srdr_host_model.sv ====
// host side reader model that drives the byte read port in bursts
`timescale 1ns/1ps
module srdr_host_model (
   // clock
   input  wire logic                 mclk_in,
   // read answer
   input  wire srdr_pkg::srdr_byte_t rd_data_in,
   input  wire logic                 rd_valid_in,
   // read request
   output logic                      addr_load_out,
   output srdr_pkg::srdr_byte_t      addr_out,
   output logic                      rd_strobe_out
);
   import srdr_pkg::*;
   srdr_byte_t got [0:15];
   int         idx;
   initial begin
      addr_load_out = 1'b0;
      addr_out = 8'h00;
      rd_strobe_out = 1'b0;
      idx = 0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // collect each answered byte
   always @(posedge mclk_in) begin
      if (rd_valid_in === 1'b1) begin
         got[idx] = rd_data_in;
         idx = idx + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // address load then back-to-back strobes
   task automatic burst(input srdr_byte_t a, input int n);
      idx = 0;
      @(negedge mclk_in);
      addr_load_out = 1'b1;
      addr_out = a;
      @(negedge mclk_in);
      addr_load_out = 1'b0;
      addr_out = ~a;
      rd_strobe_out = 1'b1;
      repeat (n) @(negedge mclk_in);
      rd_strobe_out = 1'b0;
      @(negedge mclk_in);
   endtask
endmodule

// ==== dv/sensor_result_data_registers_tb.sv ====
// self-checking bench of the result register bank
`timescale 1ns/1ps
module sensor_result_data_registers_tb;
   import srdr_pkg::*;
   typedef struct packed {
      logic       m, pe, te, dr;
      srdr_pres_t p, a;
      srdr_temp_t t;
   } srdr_row_s;
   logic        mclk_in, sys_rst_in, hms, pee, tee, drm, pv, tv, fread;
   logic        aload, strobe, rvalid;
   srdr_fmode_t fmode;
   srdr_pres_t  pdat, adat, pp, r;
   srdr_temp_t  tdat, pt;
   srdr_byte_t  addr, rdata, status;
   srdr_byte_t  e [0:11];
   int          miscompares, n_checks;
   srdr_row_s   rows [0:3] = '{
      '{1'b0, 1'b1, 1'b1, 1'b1, 20'h186a3, 20'h00123, 12'h19c},
      '{1'b1, 1'b1, 1'b0, 1'b1, 20'h18000, 20'hfd2a5, 12'hf38},
      '{1'b1, 1'b0, 1'b1, 1'b0, 20'h00000, 20'h7fff0, 12'h7ff},
      '{1'b0, 1'b1, 1'b1, 1'b0, 20'hfffff, 20'h00010, 12'h800}};

   initial mclk_in = 1'b0;
   always #50 mclk_in = ~mclk_in;

   srdr_top i_srdr_top (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .height_mode_select_in(hms), .fifo_mode_in(fmode),
      .pressure_event_enable_in(pee), .temperature_event_enable_in(tee),
      .data_ready_event_mode_in(drm),
      .pres_valid_in(pv), .pres_data_in(pdat), .alt_data_in(adat),
      .temp_valid_in(tv), .temp_data_in(tdat), .fifo_data_read_in(fread),
      .addr_load_in(aload), .addr_in(addr), .rd_strobe_in(strobe),
      .rd_data_out(rdata), .rd_valid_out(rvalid), .status_out(status));

   srdr_host_model i_srdr_host_model (
      .mclk_in(mclk_in), .rd_data_in(rdata), .rd_valid_in(rvalid),
      .addr_load_out(aload), .addr_out(addr), .rd_strobe_out(strobe));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // one pressure and temperature sample together
   task automatic sample(input srdr_pres_t p, input srdr_pres_t a, input srdr_temp_t t);
      @(negedge mclk_in);
      pv = 1'b1;
      tv = 1'b1;
      pdat = p;
      adat = a;
      tdat = t;
      @(negedge mclk_in);
      pv = 1'b0;
      tv = 1'b0;
      pdat = ~p;
      adat = ~a;
      tdat = ~t;
   endtask

   // expected bytes 01h..0bh from results and deltas
   task automatic expect_bytes(input srdr_pres_t rr, input srdr_pres_t d,
                               input srdr_temp_t tt, input srdr_temp_t dd);
      e[1] = rr[19:12];
      e[2] = rr[11:4];
      e[3] = {rr[3:0], 4'h0};
      e[4] = tt[11:4];
      e[5] = {tt[3:0], 4'h0};
      e[6] = 8'h00;
      e[7] = d[19:12];
      e[8] = d[11:4];
      e[9] = {d[3:0], 4'h0};
      e[10] = dd[11:4];
      e[11] = {dd[3:0], 4'h0};
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge mclk_in);
      miscompares++;
      give_verdict();
   end

   initial begin
      miscompares = 0;
      n_checks = 0;
      {hms, pee, tee, drm, pv, tv, fread} = 7'h00;
      fmode = 2'h0;
      pdat = 20'h00000;
      adat = 20'h00000;
      tdat = 12'h000;
      sys_rst_in = 1'b1;
      repeat (2) @(negedge mclk_in);
      sys_rst_in = 1'b0;
      i_srdr_host_model.burst(8'h00, 12);
      check(i_srdr_host_model.idx, 12);
      for (int j = 0; j < 12; j++) check(i_srdr_host_model.got[j], 8'h00);
      check(status, 8'h00);
      pp = 20'h00000;
      pt = 12'h000;
      // table rows
      for (int i = 0; i < 4; i++) begin
         hms = rows[i].m;
         pee = rows[i].pe;
         tee = rows[i].te;
         drm = rows[i].dr;
         sample(rows[i].p, rows[i].a, rows[i].t);
         r = rows[i].m ? rows[i].a : rows[i].p;
         expect_bytes(r, r - pp, rows[i].t, rows[i].t - pt);
         pp = r;
         pt = rows[i].t;
         e[0] = {4'h0, rows[i].dr, rows[i].pe, rows[i].te, 1'b0};
         i_srdr_host_model.burst(8'h00, 12);
         check(i_srdr_host_model.got[0], e[0]);
         for (int j = 1; j < 6; j++) check(i_srdr_host_model.got[j], e[j]);
         check(i_srdr_host_model.got[6], 8'h00);
         for (int j = 7; j < 12; j++) check(i_srdr_host_model.got[j], e[j]);
         check(status, 8'h00);
      end
      // overwrite without a read in between
      {hms, pee, tee, drm} = 4'h7;
      sample(20'h12345, 20'h12345, 12'h155);
      sample(20'h2468a, 20'h2468a, 12'h2aa);
      check(status, 8'hee);
      i_srdr_host_model.burst(8'h01, 1);
      check(i_srdr_host_model.got[0], 8'h24);
      check(status, 8'h22);
      i_srdr_host_model.burst(8'h04, 1);
      check(i_srdr_host_model.got[0], 8'h2a);
      check(status, 8'h00);
      // fifo on: results frozen, deltas still move
      fmode = 2'h1;
      sample(20'h13579, 20'h00000, 12'h123);
      expect_bytes(20'h2468a, 20'h13579 - 20'h2468a, 12'h2aa, 12'h123 - 12'h2aa);
      i_srdr_host_model.burst(8'h01, 11);
      for (int j = 1; j < 12; j++) check(i_srdr_host_model.got[j-1], e[j]);
      check(status, 8'h0e);
      fread = 1'b1;
      @(negedge mclk_in);
      fread = 1'b0;
      @(negedge mclk_in);
      check(status, 8'h00);
      // mid-run reset returns every register to zero
      sample(20'h0abcd, 20'h0abcd, 12'h0ab);
      @(negedge mclk_in);
      sys_rst_in = 1'b1;
      repeat (2) @(negedge mclk_in);
      sys_rst_in = 1'b0;
      i_srdr_host_model.burst(8'h00, 12);
      check(i_srdr_host_model.idx, 12);
      for (int j = 0; j < 12; j++) check(i_srdr_host_model.got[j], 8'h00);
      check(status, 8'h00);
      give_verdict();
   end
endmodule
